// ===== logic/can_rx_regs.svh
// register offsets, field positions and response codes of the receive store
`ifndef CAN_RX_REGS_SVH
`define CAN_RX_REGS_SVH
`define CTRL_OFS 12'h000
`define STATUS_OFS 12'h004
`define LAST_IN_OFS 12'h008
`define HIST_GET_OFS 12'h00c
`define MASK1_OFS 12'h010
`define BUF_REGION 3'h1
`define BUF_CONF_SEL 2'h0
`define BUF_ID_SEL 2'h1
`define BUF_DLO_SEL 2'h2
`define BUF_DHI_SEL 2'h3
`define GET_MATCH_BIT 8
`define GET_OVF_BIT 9
`define TYPE_TX 3'h0
`define TYPE_RX_NOMASK 3'h1
`define TYPE_RX_MASK4 3'h5
`define HIST_DEPTH 23
`define BUF_COUNT 32
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== logic/can_rx_pkg.sv
// types shared by the receive store and history logic
package can_rx_pkg;
	// per-buffer configuration word, high bit first in the conf register
	typedef struct packed {
		logic [3:0] dlc;          // bits 15:12
		logic buffer_received_flag; // bit 11
		logic buffer_irq_enable;  // bit 10
		logic tx_request_bit;     // bit 9
		logic rdy;                // bit 8
		logic ide;                // bit 7
		logic ows_pad;            // bit 6, reads zero
		logic overwrite_permit;   // bit 5
		logic remote_frame_select; // bit 4
		logic [2:0] buffer_type_field; // bits 3:1
		logic buffer_in_use;      // bit 0
	} buf_cfg_s;
	typedef enum logic [1:0] {
		SEL_NONE = 2'b00,
		SEL_DATA = 2'b01,
		SEL_REMOTE = 2'b10
	} store_kind_e;
endpackage : can_rx_pkg

// ===== logic/can_rx_store_history.sv
// receive buffer matching, storage and receive history list
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "can_rx_regs.svh"
module can_rx_store_history
	import can_rx_pkg::*;
#(
	parameter int NBUF = `BUF_COUNT,
	parameter int DEPTH = `HIST_DEPTH
)(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write channels
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read channels
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// received frame from the protocol engine
	input wire logic frame_valid,
	input wire logic [28:0] frame_id,
	input wire logic frame_ide,
	input wire logic frame_remote,
	input wire logic [3:0] frame_dlc,
	input wire logic [63:0] frame_data,
	// interrupt
	output logic rx_complete_irq
);
	localparam int IW = $clog2(NBUF);
	localparam int SLOTS = DEPTH + 1; // one spare slot tells full from empty
	localparam int PW = $clog2(SLOTS);

	typedef struct packed {
		logic [NBUF-1:0][63:0] buffer_data_bytes;
		logic [NBUF-1:0][28:0] id;
		buf_cfg_s [NBUF-1:0] cfg;
		logic [3:0][28:0] id_mask_bits;
		logic [SLOTS-1:0][IW-1:0] rx_history_list;
		logic [PW-1:0] history_write_ptr;
		logic [PW-1:0] history_read_ptr;
		logic history_overflow_flag;
		logic rx_complete_status;
		logic rx_irq_module_enable;
		logic aw_have;
		logic [11:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} state_s;

	state_s state_reg;
	state_s state_next;
	store_kind_e store_kind;
	logic [IW-1:0] store_num;
	logic get_read;

	// circular pointer steps
	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PW'(SLOTS - 1)) ? '0 : p + PW'(1);
	endfunction : ptr_inc

	function automatic logic [PW-1:0] ptr_dec(input logic [PW-1:0] p);
		ptr_dec = (p == '0) ? PW'(SLOTS - 1) : p - PW'(1);
	endfunction : ptr_dec

	// masked identifier compare for one buffer
	function automatic logic id_hit(input logic [28:0] a,
		input logic [28:0] b, input logic [28:0] m);
		id_hit = ((a ^ b) & ~m) == '0;
	endfunction : id_hit

	//////////////////////////////////////////////////////////////////////
	// frame search: data frames by type priority, remote frames lowest
	always_comb
	begin
		logic [28:0] msk;
		logic [NBUF-1:0] hit;
		logic found;
		logic [IW-1:0] first_free;
		logic [IW-1:0] last_hit;
		logic any_free;
		buf_cfg_s c;
		msk = '0;
		hit = '0;
		found = 1'b0;
		first_free = '0;
		last_hit = '0;
		any_free = 1'b0;
		c = '0;
		store_kind = SEL_NONE;
		store_num = '0;
		if (frame_valid && frame_remote)
		begin
			// lowest number wins; overwrite and received flag ignored
			for (int i = NBUF - 1; i >= 0; i--)
			begin
				c = state_reg.cfg[i];
				if (c.buffer_in_use && c.rdy && !c.remote_frame_select
					&& c.buffer_type_field == `TYPE_TX
					&& !c.tx_request_bit && c.ide == frame_ide
					&& state_reg.id[i] == frame_id)
				begin
					store_kind = SEL_REMOTE;
					store_num = IW'(i);
				end
			end
		end
		else if (frame_valid)
		begin
			// types 001..101 in order; first type with any hit owns frame
			for (int t = 1; t <= 5; t++)
			begin
				msk = (t == 1) ? '0 : state_reg.id_mask_bits[t-2];
				for (int i = 0; i < NBUF; i++)
				begin
					c = state_reg.cfg[i];
					hit[i] = c.buffer_in_use && c.rdy
						&& c.buffer_type_field == 3'(t) && c.ide == frame_ide
						&& id_hit(frame_id, state_reg.id[i], msk);
				end
				if (!found && hit != '0)
				begin
					found = 1'b1;
					any_free = 1'b0;
					for (int i = NBUF - 1; i >= 0; i--)
					begin
						if (hit[i] && !state_reg.cfg[i].buffer_received_flag)
						begin
							any_free = 1'b1;
							first_free = IW'(i);
						end
					end
					for (int i = 0; i < NBUF; i++)
					begin
						if (hit[i])
							last_hit = IW'(i);
					end
					if (any_free)
					begin
						store_kind = SEL_DATA;
						store_num = first_free;
					end
					else if (state_reg.cfg[last_hit].overwrite_permit)
					begin
						// group full: only its highest buffer, no wrap
						store_kind = SEL_DATA;
						store_num = last_hit;
					end
				end
			end
		end
	end

	// combinational handshakes and the module interrupt
	assign s_axi_awready = !state_reg.aw_have;
	assign s_axi_wready = !state_reg.w_have;
	assign s_axi_arready = !state_reg.rvalid;
	assign s_axi_bvalid = state_reg.bvalid;
	assign s_axi_bresp = state_reg.bresp;
	assign s_axi_rvalid = state_reg.rvalid;
	assign s_axi_rresp = state_reg.rresp;
	assign s_axi_rdata = state_reg.rdata;
	assign rx_complete_irq = state_reg.rx_complete_status
		& state_reg.rx_irq_module_enable;
	assign get_read = s_axi_arvalid && !state_reg.rvalid
		&& s_axi_araddr == `HIST_GET_OFS;

	//////////////////////////////////////////////////////////////////////
	// next state: bus slave, register writes, reads, then frame store
	always_comb
	begin
		logic [31:0] wv;
		logic [31:0] rv;
		logic ok;
		logic [IW-1:0] m;
		logic [PW-1:0] wp;
		wv = '0;
		rv = '0;
		ok = 1'b0;
		m = '0;
		wp = '0;
		state_next = state_reg;
		if (s_axi_awvalid && !state_reg.aw_have)
		begin
			state_next.aw_have = 1'b1;
			state_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !state_reg.w_have)
		begin
			state_next.w_have = 1'b1;
			state_next.w_data = s_axi_wdata;
			state_next.w_strb = s_axi_wstrb;
		end
		if (state_reg.bvalid && s_axi_bready)
			state_next.bvalid = 1'b0;
		// write once address and data are both held
		if (state_reg.aw_have && state_reg.w_have && !state_reg.bvalid)
		begin
			for (int b = 0; b < 4; b++)
				wv[b*8 +: 8] = state_reg.w_strb[b] ? state_reg.w_data[b*8 +: 8]
					: 8'h00;
			ok = 1'b1;
			m = state_reg.aw_addr[4+:IW];
			if (state_reg.aw_addr == `CTRL_OFS)
				state_next.rx_irq_module_enable = wv[0];
			else if (state_reg.aw_addr == `STATUS_OFS)
			begin
				if (wv[0])
					state_next.rx_complete_status = 1'b0; // write one clears
			end
			else if (state_reg.aw_addr[11:4] == 8'(`MASK1_OFS >> 4))
				state_next.id_mask_bits[state_reg.aw_addr[3:2]] = wv[28:0];
			else if (state_reg.aw_addr[11:9] == `BUF_REGION
				&& 32'(m) < NBUF)
			begin
				case (state_reg.aw_addr[3:2])
					`BUF_CONF_SEL: state_next.cfg[m] = buf_cfg_s'(wv[15:0]);
					`BUF_ID_SEL: state_next.id[m] = wv[28:0];
					`BUF_DLO_SEL: state_next.buffer_data_bytes[m][31:0] = wv;
					default: state_next.buffer_data_bytes[m][63:32] = wv;
				endcase
				state_next.cfg[m].ows_pad = 1'b0;
			end
			else
				ok = 1'b0;
			state_next.aw_have = 1'b0;
			state_next.w_have = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (state_reg.rvalid && s_axi_rready)
			state_next.rvalid = 1'b0;
		// read: one cycle to rvalid, get register pops the list
		if (s_axi_arvalid && !state_reg.rvalid)
		begin
			ok = 1'b1;
			m = s_axi_araddr[4+:IW];
			if (s_axi_araddr == `CTRL_OFS)
				rv[0] = state_reg.rx_irq_module_enable;
			else if (s_axi_araddr == `STATUS_OFS)
				rv[0] = state_reg.rx_complete_status;
			else if (s_axi_araddr == `LAST_IN_OFS)
				rv[IW-1:0] = state_reg.rx_history_list[
					ptr_dec(state_reg.history_write_ptr)];
			else if (get_read)
			begin
				rv[IW-1:0] =
					state_reg.rx_history_list[state_reg.history_read_ptr];
				rv[`GET_MATCH_BIT] = state_reg.history_read_ptr
					== state_reg.history_write_ptr;
				rv[`GET_OVF_BIT] = state_reg.history_overflow_flag;
				if (!rv[`GET_MATCH_BIT])
				begin
					state_next.history_read_ptr =
						ptr_inc(state_reg.history_read_ptr);
					state_next.history_overflow_flag = 1'b0;
				end
			end
			else if (s_axi_araddr[11:4] == 8'(`MASK1_OFS >> 4))
				rv[28:0] = state_reg.id_mask_bits[s_axi_araddr[3:2]];
			else if (s_axi_araddr[11:9] == `BUF_REGION && 32'(m) < NBUF)
			begin
				case (s_axi_araddr[3:2])
					`BUF_CONF_SEL: rv[15:0] = 16'(state_reg.cfg[m]);
					`BUF_ID_SEL: rv[28:0] = state_reg.id[m];
					`BUF_DLO_SEL: rv = state_reg.buffer_data_bytes[m][31:0];
					default: rv = state_reg.buffer_data_bytes[m][63:32];
				endcase
			end
			else
				ok = 1'b0;
			state_next.rvalid = 1'b1;
			state_next.rdata = rv;
			state_next.rresp = ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		// frame store wins over a same-cycle software write
		if (store_kind != SEL_NONE)
		begin
			state_next.cfg[store_num].dlc = frame_dlc;
			state_next.cfg[store_num].buffer_received_flag = 1'b1;
			if (store_kind == SEL_DATA)
				state_next.buffer_data_bytes[store_num] = frame_data;
			if (state_reg.cfg[store_num].buffer_irq_enable)
				state_next.rx_complete_status = 1'b1;
			wp = state_reg.history_write_ptr;
			// list full and no pop this cycle: newest number overwrites the last entry
			if (state_reg.history_overflow_flag
				&& state_next.history_read_ptr == state_reg.history_read_ptr)
				state_next.rx_history_list[ptr_dec(wp)] = store_num;
			else
			begin
				state_next.rx_history_list[wp] = store_num;
				state_next.history_write_ptr = ptr_inc(wp);
				if (ptr_inc(wp) == ptr_dec(state_next.history_read_ptr))
					state_next.history_overflow_flag = 1'b1;
			end
		end
	end

	// state register with synchronous reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	//////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_hist_advance;
		store_kind != SEL_NONE && !state_reg.history_overflow_flag
		|=> state_reg.history_write_ptr
			== ptr_inc($past(state_reg.history_write_ptr));
	endproperty
	a_hist_advance: assert property (p_hist_advance)
		else $error("write pointer did not advance on store");

	property p_last_in;
		store_kind != SEL_NONE |=> state_reg.rx_history_list[
			ptr_dec(state_reg.history_write_ptr)] == $past(store_num);
	endproperty
	a_last_in: assert property (p_last_in)
		else $error("last entry is not the stored buffer number");

	property p_get_pop;
		get_read && state_reg.history_read_ptr
			!= state_reg.history_write_ptr
		|=> state_reg.history_read_ptr
			== ptr_inc($past(state_reg.history_read_ptr)) ##1 1'b1;
	endproperty
	a_get_pop: assert property (p_get_pop)
		else $error("read pointer did not advance on get");

	property p_not_empty;
		store_kind != SEL_NONE && !state_reg.history_overflow_flag
		|=> state_reg.history_read_ptr != state_reg.history_write_ptr;
	endproperty
	a_not_empty: assert property (p_not_empty)
		else $error("pointers still match after a new entry");

	property p_ovf_set;
		store_kind != SEL_NONE && !get_read
		&& ptr_inc(state_reg.history_write_ptr)
			== ptr_dec(state_reg.history_read_ptr)
		|=> state_reg.history_overflow_flag;
	endproperty
	a_ovf_set: assert property (p_ovf_set)
		else $error("overflow flag not set when list filled");

	property p_full_hold;
		store_kind != SEL_NONE && state_reg.history_overflow_flag
		&& !get_read |=> $stable(state_reg.history_write_ptr);
	endproperty
	a_full_hold: assert property (p_full_hold)
		else $error("write pointer moved while list full");

	property p_status;
		store_kind != SEL_NONE
		&& state_reg.cfg[store_num].buffer_irq_enable
		|=> state_reg.rx_complete_status
			##1 (rx_complete_irq || !state_reg.rx_irq_module_enable
				|| !state_reg.rx_complete_status);
	endproperty
	a_status: assert property (p_status)
		else $error("receive status not set by enabled buffer");

	property p_remote_data;
		store_kind == SEL_REMOTE |=> state_reg.buffer_data_bytes
			== $past(state_reg.buffer_data_bytes)
			|| $past(state_reg.aw_have && state_reg.w_have);
	endproperty
	a_remote_data: assert property (p_remote_data)
		else $error("remote frame changed buffer data");

	property p_no_clobber;
		store_kind == SEL_DATA
		|-> !state_reg.cfg[store_num].buffer_received_flag
			|| state_reg.cfg[store_num].overwrite_permit;
	endproperty
	a_no_clobber: assert property (p_no_clobber)
		else $error("received buffer overwritten without permit");
endmodule : can_rx_store_history

// ===== test/can_frame_src.sv
// protocol engine stand-in that hands received frames to the store
`timescale 1ns/100ps
module can_frame_src
(
	// clock
	input wire logic aclk,
	// request from the bench
	input wire logic send,
	input wire logic [28:0] id,
	input wire logic remote,
	input wire logic [63:0] data,
	// frame towards the receive store
	output logic frame_valid,
	output logic [28:0] frame_id,
	output logic frame_ide,
	output logic frame_remote,
	output logic [3:0] frame_dlc,
	output logic [63:0] frame_data
);
	////////////////////////////////////////////////////////////////////
	// quiet start so idle scrambling has a known base
	initial
	begin
		{frame_valid, frame_id, frame_ide} = '0;
		{frame_remote, frame_dlc, frame_data} = '0;
	end

	// one-cycle frame pulse, fields scrambled between frames
	always @(posedge aclk)
	begin
		frame_valid <= send;
		if (send)
		begin
			frame_id <= id;
			frame_ide <= 1'b0;
			frame_remote <= remote;
			frame_dlc <= 4'h5;
			frame_data <= data;
		end
		else
		begin
			frame_id <= ~frame_id;
			frame_ide <= ~frame_ide;
			frame_remote <= ~frame_remote;
			frame_dlc <= ~frame_dlc;
			frame_data <= ~frame_data;
		end
	end
endmodule : can_frame_src

// ===== test/can_rx_store_history_tb.sv
// self-checking bench of the receive store and history list
`timescale 1ns/100ps
`include "can_rx_regs.svh"
`define CHK(n, e, g) begin \
	samples_checked++; \
	if ((g) !== (e)) \
	begin \
		failures++; \
		$display("mismatch %s expected %h seen %h", n, e, g); \
	end \
end
module can_rx_store_history_tb;
	typedef struct packed
	{
		logic [28:0] id;
		logic rmt;
		logic hit;
		logic [4:0] num;
	} row_s;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irq, send, f_rmt;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, g;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [28:0] f_id;
	logic fv, fide, frem;
	logic [28:0] fid;
	logic [3:0] fdlc;
	logic [63:0] fdat;
	int failures = 0;
	int samples_checked = 0;
	row_s rows [8] = '{
		'{29'h100, 1'b0, 1'b1, 5'd0},
		'{29'h100, 1'b0, 1'b0, 5'd0},
		'{29'h205, 1'b0, 1'b1, 5'd2},
		'{29'h20a, 1'b0, 1'b1, 5'd3},
		'{29'h203, 1'b0, 1'b0, 5'd0},
		'{29'h300, 1'b1, 1'b1, 5'd5},
		'{29'h300, 1'b1, 1'b1, 5'd5},
		'{29'h555, 1'b0, 1'b0, 5'd0}
	};

	////////////////////////////////////////////////////////////////////
	// design, frame source and clock
	can_rx_store_history dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .frame_valid(fv),
		.frame_id(fid), .frame_ide(fide), .frame_remote(frem),
		.frame_dlc(fdlc), .frame_data(fdat), .rx_complete_irq(irq));
	can_frame_src src_u (.aclk(aclk), .send(send), .id(f_id),
		.remote(f_rmt), .data({3'h0, f_id, 3'h0, f_id}), .frame_valid(fv),
		.frame_id(fid), .frame_ide(fide), .frame_remote(frem),
		.frame_dlc(fdlc), .frame_data(fdat));

	// free-running clock
	initial
	begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	////////////////////////////////////////////////////////////////////
	// bus, frame and verdict tasks
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		g = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic buf_set(input int m, input logic [31:0] c, input int i);
		wr(12'h200 + 12'(m * 16) + {8'h0, `BUF_CONF_SEL, 2'b0}, c);
		wr(12'h200 + 12'(m * 16) + {8'h0, `BUF_ID_SEL, 2'b0}, 32'(i));
	endtask : buf_set

	function automatic logic [31:0] cfg(input logic [2:0] t, input logic o,
		input logic ie);
		return {21'h0, ie, 1'b0, 1'b1, 2'b0, o, 1'b0, t, 1'b1};
	endfunction : cfg

	task automatic send_frame(input logic [28:0] i, input logic rm);
		@(posedge aclk);
		send <= 1'b1;
		f_id <= i;
		f_rmt <= rm;
		@(posedge aclk);
		send <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask : send_frame

	task automatic print_verdict();
		if (failures == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict

	// watchdog against a hung handshake
	initial
	begin
		repeat (20000) @(posedge aclk);
		failures++;
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, send} = '0;
		{awaddr, araddr, wdata, f_id, f_rmt} = '0;
		wstrb = 4'hf;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`HIST_GET_OFS);
		`CHK("empty match", 1'b1, g[8])
		`CHK("reset irq", 1'b0, irq)
		// buffers: unmasked, mask-1 and mask-2 groups, transmit pair, one unused
		wr(`MASK1_OFS, 32'hf);
		wr(`MASK1_OFS + 12'h4, 32'hf);
		buf_set(0, cfg(3'h1, 1'b0, 1'b1), 'h100);
		buf_set(2, cfg(3'h2, 1'b0, 1'b0), 'h200);
		buf_set(3, cfg(3'h2, 1'b0, 1'b0), 'h201);
		buf_set(4, cfg(3'h2, 1'b0, 1'b0), 'h10f);
		buf_set(7, cfg(3'h3, 1'b0, 1'b0), 'h200);
		buf_set(5, cfg(3'h0, 1'b0, 1'b0), 'h300);
		buf_set(6, cfg(3'h0, 1'b0, 1'b0), 'h300);
		buf_set(8, 32'h102, 'h555);
		wr(12'h258, 32'h11223344);
		foreach (rows[k])
		begin
			send_frame(rows[k].id, rows[k].rmt);
			rd(`HIST_GET_OFS);
			`CHK("get match", ~rows[k].hit, g[8])
			if (rows[k].hit)
				`CHK("get number", rows[k].num, g[4:0])
		end
		rd(`LAST_IN_OFS);
		`CHK("last in", 5'd5, g[4:0])
		rd(12'h258);
		`CHK("remote data kept", 32'h11223344, g)
		rd(12'h250);
		`CHK("remote dlc and flag", 5'h0b, g[15:11])
		rd(`STATUS_OFS);
		`CHK("rx status", 1'b1, g[0])
		`CHK("irq gated", 1'b0, irq)
		wr(`CTRL_OFS, 32'h1);
		@(posedge aclk);
		`CHK("irq enabled", 1'b1, irq)
		wr(`STATUS_OFS, 32'h1);
		@(posedge aclk);
		`CHK("irq cleared", 1'b0, irq)
		// fill the list past full with overwrite-permitted buffers
		buf_set(0, cfg(3'h1, 1'b1, 1'b0), 'h100);
		buf_set(1, cfg(3'h1, 1'b1, 1'b0), 'h101);
		repeat (23) send_frame(29'h100, 1'b0);
		send_frame(29'h101, 1'b0);
		rd(`LAST_IN_OFS);
		`CHK("overwritten last", 5'd1, g[4:0])
		for (int i = 0; i < 23; i++)
		begin
			rd(`HIST_GET_OFS);
			`CHK("full list", (i == 22) ? 5'd1 : 5'd0, g[4:0])
			if (i == 0)
				`CHK("overflow", 1'b1, g[9])
		end
		rd(`HIST_GET_OFS);
		`CHK("drained match", 1'b1, g[8])
		// reset in mid-run empties the list and drops the module enable
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`LAST_IN_OFS);
		`CHK("reset last in", 5'd0, g[4:0])
		rd(`CTRL_OFS);
		`CHK("reset enable", 1'b0, g[0])
		rd(`HIST_GET_OFS);
		`CHK("reset match", 1'b1, g[8])
		wr(12'h100, 32'h1);
		`CHK("unmapped write", `RESP_SLVERR, r)
		rd(12'h100);
		`CHK("unmapped read", `RESP_SLVERR, r)
		print_verdict();
	end
endmodule : can_rx_store_history_tb
